// ==== uart_pkg.sv ====
// constants shared by the debug uart core and its shift engine
// assumes a 16-bit processor register port on the 10 MHz system clock
// How it works
// - idle transmit line held high
// - start, eight data lsb first, stop
// - stop bit low sets framing error
// - overrun takes previous receive-full state
// - receive-full set on load, read clears
// - status bit 1 means transmit register occupied
// - status bit 0 high while shifting
// - low view reads byte, upper zeros
// - receive irq on each byte transfer
// - low write idle: load, irq, send
// - busy write held until frame ends
// - high view same, byte in 15:8
// - reset clears divider register to zero
// - bit rate master over (d1+1)*d2
// - oversample tick is first divider output
// - start on falling edge, mid-bit sampling
// - after stop check receiver returns idle
package uart_pkg;
  localparam logic [15:0] LINE_STATUS_ADDR = 16'hc028;
  localparam logic [15:0] BYTE_PORT_LOW_ADDR = 16'hc029;
  localparam logic [15:0] BYTE_PORT_HIGH_ADDR = 16'hc02a;
  localparam logic [15:0] BAUD_DIVIDER_ADDR = 16'hc02b;
  localparam logic [15:0] BAUD_DIVIDER_RESET = 16'h0000;
  localparam int FRAMING_ERROR_BIT = 4;
  localparam int OVERRUN_BIT = 3;
  localparam int RECEIVE_FULL_BIT = 2;
  localparam int TRANSMIT_FULL_BIT = 1;
  localparam int TRANSMITTER_ACTIVE_BIT = 0;
  localparam int FRAME_DATA_BITS = 8;
  localparam int MIN_SECOND_DIVIDER = 6;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : uart_pkg

// ==== uart_tx_engine.sv ====
// transmit shift engine: sends one framed byte per load
// assumes a one-cycle bit tick from the baud divider in the core
`timescale 1ns/100ps
module uart_tx_engine (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [7:0] load_byte,
  input wire logic bit_tick,
  output logic busy,
  output logic txd
);
  import uart_pkg::*;
  typedef struct packed {
    logic busy;
    logic txd;
    logic [8:0] shreg;
    logic [3:0] left;
  } tx_state_t;
  tx_state_t s_q, s_d;

  // shift out start, data and stop; line rests high between frames
  always_comb begin
    s_d = s_q;
    if (load && !s_q.busy) begin
      s_d.busy = 1'b1;
      s_d.txd = 1'b0;
      s_d.shreg = {1'b1, load_byte};
      s_d.left = 4'(FRAME_DATA_BITS + 1);
    end else if (s_q.busy && bit_tick) begin
      if (s_q.left == 4'h0) begin
        s_d.busy = 1'b0;
      end else begin
        s_d.txd = s_q.shreg[0];
        s_d.shreg = {1'b1, s_q.shreg[8:1]};
        s_d.left = s_q.left - 4'h1;
      end
    end
    if (!s_d.busy) begin
      s_d.txd = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{busy: 1'b0, txd: 1'b1, shreg: 9'h1ff, left: 4'h0};
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign txd = s_q.txd;

  AST_IDLE_HIGH: assert property (@(posedge sys_clk) disable iff (!nrst)
    !busy |-> txd) else $error("tx line low while idle");
endmodule // uart_tx_engine

// ==== uart_debug_port.sv ====
// debug uart: register port, two-stage baud divider, rx and tx
// assumes a single-cycle processor register port with read strobe
`timescale 1ns/100ps
module uart_debug_port (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic transmit_irq,
  output logic receive_irq,
  output logic txd,
  input wire logic rxd
);
  import uart_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
    logic [15:0] divider;
    logic [7:0] first_cnt;
    logic [7:0] second_cnt;
    logic [7:0] tx_hold;
    logic transmit_full_flag;
    logic tx_load;
    logic [7:0] tx_byte;
    logic transmit_irq;
    logic [7:0] rx_data;
    logic receive_full_flag;
    logic overrun_flag;
    logic framing_error_flag;
    logic receive_irq;
    logic rx_sync1;
    logic rx_sync2;
    logic rx_prev;
    rx_state_t rx_state;
    logic [8:0] rx_time;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
  } core_state_t;
  core_state_t s_q, s_d;

  logic tx_busy;
  logic bit_tick;
  logic os_tick;

  function automatic logic [7:0] pick_byte(input logic [15:0] addr,
                                           input logic [15:0] w);
    pick_byte = (addr == BYTE_PORT_HIGH_ADDR) ? w[15:8] : w[7:0];
  endfunction

  function automatic logic is_data_view(input logic [15:0] addr);
    is_data_view = (addr == BYTE_PORT_LOW_ADDR) ||
                   (addr == BYTE_PORT_HIGH_ADDR);
  endfunction

  // one oversample step short of the limit; shared by the start, data and stop phases
  function automatic logic step_done(input logic [8:0] t,
                                     input logic [7:0] lim);
    step_done = (t[7:0] + 8'h01 >= lim);
  endfunction

  // the shifters and counters are sized for byte frames only
  if (FRAME_DATA_BITS != 8 || MIN_SECOND_DIVIDER < 2) begin : g_bad_cfg
    $error("frame or divider constants not supported");
  end

  assign os_tick = (s_q.first_cnt == s_q.divider[15:8]);
  assign bit_tick = os_tick && (s_q.second_cnt + 8'h01 >= s_q.divider[7:0]);

  uart_tx_engine u_tx (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .load(s_q.tx_load),
    .load_byte(s_q.tx_byte),
    .bit_tick(bit_tick),
    .busy(tx_busy),
    .txd(txd)
  );

  always_comb begin
    logic [7:0] half;
    half = {1'b0, s_q.divider[7:1]};
    s_d = s_q;
    s_d.tx_load = 1'b0;
    s_d.transmit_irq = 1'b0;
    s_d.receive_irq = 1'b0;

    // divider chain runs freely; counters restart on rollover
    s_d.first_cnt = os_tick ? 8'h00 : s_q.first_cnt + 8'h01;
    if (bit_tick) begin
      s_d.second_cnt = 8'h00;
    end else if (os_tick) begin
      s_d.second_cnt = s_q.second_cnt + 8'h01;
    end

    s_d.rx_sync1 = rxd;
    s_d.rx_sync2 = s_q.rx_sync1;
    s_d.rx_prev = s_q.rx_sync2;

    // status and data reads, no flag side effect on status
    s_d.rdata = 16'h0000;
    if (reg_rd) begin
      case (reg_addr)
        LINE_STATUS_ADDR: s_d.rdata = {11'h000, s_q.framing_error_flag,
          s_q.overrun_flag, s_q.receive_full_flag,
          s_q.transmit_full_flag, tx_busy};
        BYTE_PORT_LOW_ADDR: s_d.rdata = {8'h00, s_q.rx_data};
        BYTE_PORT_HIGH_ADDR: s_d.rdata = {s_q.rx_data, 8'h00};
        BAUD_DIVIDER_ADDR: s_d.rdata = s_q.divider;
        default: s_d.rdata = 16'h0000;
      endcase
      if (is_data_view(reg_addr)) begin
        s_d.receive_full_flag = 1'b0;
      end
    end

    if (reg_wr && reg_addr == BAUD_DIVIDER_ADDR) begin
      s_d.divider = reg_wdata;
    end

    // idle write loads shifter at once
    if (reg_wr && is_data_view(reg_addr)) begin
      if (!tx_busy && !s_q.transmit_full_flag && !s_q.tx_load) begin
        s_d.tx_load = 1'b1;
        s_d.tx_byte = pick_byte(reg_addr, reg_wdata);
        s_d.transmit_irq = 1'b1;
      end else begin
        // busy write held in data register
        s_d.tx_hold = pick_byte(reg_addr, reg_wdata);
        s_d.transmit_full_flag = 1'b1;
      end
    end else if (s_q.transmit_full_flag && !tx_busy && !s_q.tx_load) begin
      s_d.tx_load = 1'b1;
      s_d.tx_byte = s_q.tx_hold;
      s_d.transmit_irq = 1'b1;
      s_d.transmit_full_flag = 1'b0;
    end

    case (s_q.rx_state)
      RX_IDLE: begin
        if (s_q.rx_prev && !s_q.rx_sync2) begin
          s_d.rx_state = RX_START;
          s_d.rx_time = 9'h000;
        end
      end
      RX_START: begin
        if (os_tick) begin
          s_d.rx_time = s_q.rx_time + 9'h001;
          if (step_done(s_q.rx_time, half)) begin
            s_d.rx_time = 9'h000;
            s_d.rx_bit = 3'h0;
            s_d.rx_state = s_q.rx_sync2 ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (os_tick) begin
          s_d.rx_time = s_q.rx_time + 9'h001;
          if (step_done(s_q.rx_time, s_q.divider[7:0])) begin
            s_d.rx_time = 9'h000;
            s_d.rx_shift = {s_q.rx_sync2, s_q.rx_shift[7:1]};
            s_d.rx_bit = s_q.rx_bit + 3'h1;
            if (s_q.rx_bit == 3'(FRAME_DATA_BITS - 1)) begin
              s_d.rx_state = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (os_tick) begin
          s_d.rx_time = s_q.rx_time + 9'h001;
          if (step_done(s_q.rx_time, s_q.divider[7:0])) begin
            s_d.rx_data = s_q.rx_shift;
            s_d.framing_error_flag = !s_q.rx_sync2;
            s_d.overrun_flag = s_q.receive_full_flag;
            // load sets full, wins over read
            s_d.receive_full_flag = 1'b1;
            s_d.receive_irq = 1'b1;
            s_d.rx_state = RX_IDLE;
          end
        end
      end
      default: s_d.rx_state = RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.divider <= BAUD_DIVIDER_RESET;
      s_q.rx_sync1 <= 1'b1;
      s_q.rx_sync2 <= 1'b1;
      s_q.rx_prev <= 1'b1;
      s_q.rx_state <= RX_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign transmit_irq = s_q.transmit_irq;
  assign receive_irq = s_q.receive_irq;

  AST_TX_IRQ_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst)
    transmit_irq |-> ##1 tx_busy) else $error("tx irq without start");

  AST_TX_IRQ_BYTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == BYTE_PORT_LOW_ADDR && !tx_busy &&
     !s_q.transmit_full_flag && !s_q.tx_load)
    |=> transmit_irq && s_q.tx_byte == $past(reg_wdata[7:0]))
    else $error("idle write not loaded");

  AST_RX_FULL: assert property (@(posedge sys_clk) disable iff (!nrst)
    receive_irq |-> s_q.receive_full_flag) else $error("full not set");

  AST_RX_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && is_data_view(reg_addr) && !(s_q.rx_state == RX_STOP &&
     s_d.rx_state == RX_IDLE)) |=> !s_q.receive_full_flag)
    else $error("full not cleared");

  AST_RX_IRQ_ONE: assert property (@(posedge sys_clk) disable iff (!nrst)
    receive_irq |=> !receive_irq) else $error("rx irq too long");

  AST_RX_IRQ_LOAD: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_q.rx_state == RX_STOP && s_d.rx_state == RX_IDLE) |=> receive_irq)
    else $error("store without irq");

  AST_OVERRUN: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_q.rx_state == RX_STOP && s_d.rx_state == RX_IDLE)
    |=> s_q.overrun_flag == $past(s_q.receive_full_flag))
    else $error("overrun wrong");

  AST_FRAME_ERR: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_q.rx_state == RX_STOP && s_d.rx_state == RX_IDLE)
    |=> s_q.framing_error_flag == !$past(s_q.rx_sync2))
    else $error("framing flag wrong");

  AST_RX_IDLE_AFTER: assert property (@(posedge sys_clk) disable iff (!nrst)
    receive_irq |-> s_q.rx_state == RX_IDLE)
    else $error("receiver not idle");

  AST_START_EDGE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_q.rx_state == RX_IDLE && s_q.rx_prev && !s_q.rx_sync2)
    |=> s_q.rx_state == RX_START) else $error("start missed");

  AST_HOLD_SENT: assert property (@(posedge sys_clk) disable iff (!nrst)
    (s_q.transmit_full_flag && !tx_busy && !s_q.tx_load && !reg_wr)
    |=> s_q.tx_load) else $error("held byte not loaded");

  AST_HOLD_FLAG: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && is_data_view(reg_addr) && tx_busy)
    |=> s_q.transmit_full_flag) else $error("busy write not held");

  AST_STATUS_NOWRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == LINE_STATUS_ADDR) |=> $stable(s_q.divider))
    else $error("status write changed state");

  AST_STATUS_BUSY: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == LINE_STATUS_ADDR)
    |=> reg_rdata[TRANSMITTER_ACTIVE_BIT] == $past(tx_busy))
    else $error("running bit wrong");

  AST_STATUS_TXFULL: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == LINE_STATUS_ADDR)
    |=> reg_rdata[TRANSMIT_FULL_BIT] == $past(s_q.transmit_full_flag))
    else $error("transmit full bit wrong");

  AST_LOW_VIEW: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == BYTE_PORT_LOW_ADDR) |=> reg_rdata[15:8] == 8'h00)
    else $error("low view upper bits set");

  AST_HIGH_VIEW: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == BYTE_PORT_HIGH_ADDR)
    |=> reg_rdata[7:0] == 8'h00) else $error("high view low bits set");

  AST_HIGH_BYTE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_rd && reg_addr == BYTE_PORT_HIGH_ADDR)
    |=> reg_rdata[15:8] == $past(s_q.rx_data))
    else $error("high view byte wrong");

  AST_DIV_WRITE: assert property (@(posedge sys_clk) disable iff (!nrst)
    (reg_wr && reg_addr == BAUD_DIVIDER_ADDR)
    |=> s_q.divider == $past(reg_wdata)) else $error("divider lost");

  AST_BIT_TICK: assert property (@(posedge sys_clk) disable iff (!nrst)
    bit_tick |-> os_tick) else $error("bit tick off grid");

  AST_SYNC: assert property (@(posedge sys_clk) disable iff (!nrst)
    s_q.rx_sync2 == $past(s_q.rx_sync1)) else $error("sync stage");

  // main scenarios worth seeing
  COV_TX: cover property (@(posedge sys_clk) transmit_irq);
  COV_RX: cover property (@(posedge sys_clk) receive_irq);
  COV_OVR: cover property (@(posedge sys_clk) receive_irq && s_q.overrun_flag);
  COV_FE: cover property (@(posedge sys_clk)
    receive_irq && s_q.framing_error_flag);
  COV_HELD: cover property (@(posedge sys_clk)
    s_q.transmit_full_flag && tx_busy);
endmodule // uart_debug_port

// ==== uart_peer.sv ====
// remote serial terminal: sends frames on rxd, decodes frames on txd
// assumes BIT sys_clk cycles per bit and test bytes with bit 0 set
`timescale 1ns/100ps
module uart_peer #(parameter int BIT = 12) (
  input wire logic sys_clk,
  input wire logic txd,
  output logic rxd
);
  logic [8:0] got[$];

  // idle line sits high, as a pulled-up rs232 line
  initial rxd = 1'b1;

  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge sys_clk) rxd = f[i];
      repeat (BIT - 1) @(negedge sys_clk);
    end
    @(negedge sys_clk) rxd = 1'b1;
  endtask

  // decode frames
  // timed from the start-to-d0 edge, since the start bit may be short
  always begin : decode
    logic [8:0] v;
    @(negedge txd);
    @(posedge txd);
    for (int i = 0; i < 9; i++) begin
      repeat (i == 0 ? BIT / 2 : BIT) @(posedge sys_clk);
      v[i] = txd;
    end
    got.push_back(v);
  end
endmodule // uart_peer

// ==== rs232_uart_debug_port_bench.sv ====
// self-checking bench for the debug uart, with a serial peer model
// assumes divider 16'h0106, so one bit is 12 system clocks
`timescale 1ns/100ps
module rs232_uart_debug_port_bench;
  import uart_pkg::*;
  localparam int BIT = 12;
  logic sys_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
  logic transmit_irq, receive_irq, txd, rxd;
  int mismatches = 0, tests_run = 0;

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  uart_debug_port i_dut (.sys_clk(sys_clk), .nrst(nrst),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .transmit_irq(transmit_irq), .receive_irq(receive_irq),
    .txd(txd), .rxd(rxd));
  uart_peer #(.BIT(BIT)) i_peer (.sys_clk(sys_clk), .txd(txd), .rxd(rxd));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobes last one cycle; inputs move on falling edges only
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask

  // read data is registered and stands one cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    check(reg_rdata, exp);
  endtask

  // catch a one-cycle irq pulse within lim cycles
  task automatic pulse(input logic rx, input int lim, input logic exp);
    logic hit;
    // a pulse launched by the caller's last edge still stands here
    hit = rx ? receive_irq : transmit_irq;
    for (int i = 0; i < lim && !hit; i++) begin
      @(negedge sys_clk);
      hit = rx ? receive_irq : transmit_irq;
    end
    check({15'h0, hit}, {15'h0, exp});
  endtask

  task automatic t_reset();
    rd(BAUD_DIVIDER_ADDR, 16'h0000);
    rd(LINE_STATUS_ADDR, 16'h0000);
    rd(16'hc02c, 16'h0000);
    check({15'h0, txd}, 16'h0001);
    $display("test reset done");
  endtask

  task automatic t_tx();
    wr(BAUD_DIVIDER_ADDR, 16'h0106);
    rd(BAUD_DIVIDER_ADDR, 16'h0106);
    wr(BYTE_PORT_LOW_ADDR, 16'hffa5);
    pulse(1'b0, 3, 1'b1);
    rd(LINE_STATUS_ADDR, 16'h0001);
    // next byte held in register while first one shifts
    wr(BYTE_PORT_HIGH_ADDR, 16'h6b00);
    rd(LINE_STATUS_ADDR, 16'h0003);
    pulse(1'b0, 13 * BIT, 1'b1);
    for (int i = 0; i < 12 * BIT && i_peer.got.size() < 2; i++)
      @(negedge sys_clk);
    check({7'h0, i_peer.got.pop_front()}, 16'h01a5);
    check({7'h0, i_peer.got.pop_front()}, 16'h016b);
    $display("test transmit done");
  endtask

  task automatic t_rx();
    fork
      i_peer.send(8'h3c, 1'b1);
      pulse(1'b1, 12 * BIT, 1'b1);
    join
    rd(LINE_STATUS_ADDR, 16'h0004);
    rd(BYTE_PORT_LOW_ADDR, 16'h003c);
    wr(LINE_STATUS_ADDR, 16'h001f);
    rd(LINE_STATUS_ADDR, 16'h0000);
    $display("test receive done");
  endtask

  // back-to-back frames unread, then a low stop bit
  task automatic t_err();
    i_peer.send(8'h11, 1'b1);
    i_peer.send(8'h22, 1'b1);
    rd(LINE_STATUS_ADDR, 16'h000c);
    rd(BYTE_PORT_HIGH_ADDR, 16'h2200);
    i_peer.send(8'h55, 1'b0);
    rd(LINE_STATUS_ADDR, 16'h0014);
    $display("test errors done");
  endtask

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence after six cycles of reset
  initial begin
    repeat (6) @(negedge sys_clk);
    nrst = 1'b1;
    t_reset();
    t_tx();
    t_rx();
    t_err();
    summarize();
  end

  // hang guard, about five times the expected run
  initial begin : watchdog
    repeat (4000) @(posedge sys_clk);
    mismatches++;
    summarize();
  end
endmodule // rs232_uart_debug_port_bench
